//--- hdl/data_file.v
// Data register file, 128 bytes, one write port and one read port
`timescale 1ns/1ns
module data_file (
    input  wire       clk_i,
    input  wire       we_i,
    input  wire [6:0] waddr_i,
    input  wire [7:0] wdata_i,
    input  wire [6:0] raddr_i,
    output wire [7:0] rdata_o
);
    reg [7:0] mem [0:127];

    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[raddr_i];
endmodule // data_file

//--- hdl/mcu_exec_consts.vh
// Constants for the instruction execution core
`ifndef MCU_EXEC_CONSTS_VH
`define MCU_EXEC_CONSTS_VH

// Instruction cycle divider, clocks per instruction cycle
`define CYC_DIV           4
`define CYC_CNT_W         2

// Bus register byte offsets
`define OFS_CTRL          8'h00
`define OFS_STATUS        8'h04
`define OFS_ACCUM         8'h08
`define OFS_PC            8'h0C
`define OFS_OPTION        8'h10
`define OFS_INTCTL        8'h14
`define OFS_PCLATCH       8'h18
`define OFS_WDOG          8'h1C

// Control register fields
`define CTRL_RUN          0
`define CTRL_WAKE         1

// Status byte fields
`define ST_CARRY          0
`define ST_DCARRY         1
`define ST_ZERO           2
`define ST_PDOWN          3
`define ST_WDEXP          4
`define ST_HALT           5

// Interrupt control field
`define IC_GIE            7

// File addresses decoded by the core
`define FA_STATUS         7'h03
`define FA_OPTION         7'h01
`define FA_PCLATCH        7'h0A
`define FA_INTCTL         7'h0B

// Reset values
`define RST_OPTION        8'hFF
`define RST_INTCTL        8'h00
`define RST_PC            13'h0000
`define NOP_WORD          14'h0000

// Fixed opcodes
`define OP_OPTION         14'h0062
`define OP_SLEEP          14'h0063
`define OP_INTERRUPT_RETURN_OP         14'h0009
`define OP_RETURN         14'h0008

`endif

//--- hdl/mcu_exec_core.v
// Instruction decode and execute core with a Wishbone register slave
// What this block does
// RULE_01: A set bit under bit_test_skip_if_one discards the prefetched word and runs a no-op.
// RULE_02: A subroutine jump pushes the next address, loads bits 10..0 from the word, 12..11 from latch bits 4..3.
// RULE_03: register_clear_op writes zero to the register and sets zero, in one cycle.
// RULE_04: increment_skip_if_zero adds one, touches no flag, and skips on a zero result.
// RULE_05: Destination bit 0 sends the result to the accumulator, 1 back to the register.
// RULE_06: Register and literal OR combine with the accumulator and update zero.
// RULE_07: load_literal_op loads the literal into the accumulator with no flag change.
// RULE_08: store_accum_op copies the accumulator into the register with no flag change.
// RULE_09: The legacy option opcode copies the accumulator into the option register, also bus reachable.
// RULE_10: literal_return_op loads the literal, pops the stack top into the counter, two cycles.
// RULE_11: rotate_left_thru_carry moves carry into bit 0 and bit 7 into carry, only carry changes.
// RULE_12: rotate_right_thru_carry moves carry into bit 7 and bit 0 into carry, only carry changes.
// RULE_13: Power-down clears watchdog and prescaler, sets expiry flag, clears power-down flag, halts.
// RULE_14: interrupt_return_op pops the stack and sets global_irq_enable; plain return only pops.
// RULE_15: literal_minus_accum_op computes literal minus accumulator, updating carry, digit carry, zero.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "mcu_exec_consts.vh"
module mcu_exec_core (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [13:0] prog_data_i,
    output reg  [12:0] prog_addr_o,
    output reg         sleep_o
);
    // Architectural state
    reg  [7:0]  accum;
    reg  [7:0]  option_reg;
    reg  [7:0]  interrupt_control_reg;
    reg  [7:0]  pc_high_latch;
    reg         carry_flag;
    reg         digit_carry_flag;
    reg         zero_flag;
    reg         watchdog_expiry_flag;
    reg         power_down_flag;
    reg         run;
    reg  [13:0] ir;
    reg  [12:0] stack [0:7];
    reg  [2:0]  sp;
    reg  [7:0]  wdog_count;
    reg  [7:0]  wdog_presc;
    reg  [`CYC_CNT_W-1:0] div_count;
    reg         cyc_en;

    // Combinational execute results
    reg  [7:0]  result;
    reg         write_dest;
    reg         flush;
    reg         do_push;
    reg         do_pop;
    reg  [12:0] next_pc;
    reg         next_carry;
    reg         next_dcarry;
    reg         next_zero;
    reg         acc_load;
    reg  [7:0]  acc_value;
    reg         opt_load;
    reg         set_gie;
    reg         go_sleep;
    reg  [8:0]  diff;
    reg  [4:0]  diff_lo;

    wire [6:0]  faddr = ir[6:0];
    wire [7:0]  lit   = ir[7:0];
    wire        dest  = ir[7];
    wire [2:0]  bsel  = ir[9:7];
    wire        d_form = (ir[13:8] == 6'b000100) | (ir[13:8] == 6'b001111) |
                         (ir[13:8] == 6'b001101) | (ir[13:8] == 6'b001100);
    wire [7:0]  file_rdata;
    wire        step  = cyc_en & run & ~sleep_o;
    wire        file_we = step & write_dest;
    wire        special = (faddr == `FA_STATUS) | (faddr == `FA_OPTION) |
                          (faddr == `FA_PCLATCH) | (faddr == `FA_INTCTL);
    wire [7:0]  status_byte = {2'b00, sleep_o, watchdog_expiry_flag, power_down_flag,
                               zero_flag, digit_carry_flag, carry_flag};
    reg  [7:0]  operand;

    data_file u_file (
        .clk_i   (clk_i),
        .we_i    (file_we & ~special),
        .waddr_i (faddr),
        .wdata_i (result),
        .raddr_i (faddr),
        .rdata_o (file_rdata)
    );

    // Operand read with special file registers
    always @* begin
        case (faddr)
            `FA_STATUS:  operand = status_byte;
            `FA_OPTION:  operand = option_reg;
            `FA_PCLATCH: operand = pc_high_latch;
            `FA_INTCTL:  operand = interrupt_control_reg;
            default:     operand = file_rdata;
        endcase
    end

    // Decode and execute
    always @* begin
        result      = 8'h00;
        write_dest  = 1'b0;
        flush       = 1'b0;
        do_push     = 1'b0;
        do_pop      = 1'b0;
        next_pc     = prog_addr_o + 13'h0001;
        next_carry  = carry_flag;
        next_dcarry = digit_carry_flag;
        next_zero   = zero_flag;
        acc_load    = 1'b0;
        acc_value   = 8'h00;
        opt_load    = 1'b0;
        set_gie     = 1'b0;
        go_sleep    = 1'b0;
        diff        = {1'b0, lit} + {1'b0, ~accum} + 9'h001;
        diff_lo     = {1'b0, lit[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;
        if (ir[13:10] == 4'b0111) begin
            if (operand[bsel]) begin
                flush = 1'b1; // RULE_01
            end
        end else if (ir[13:11] == 3'b100) begin
            do_push = 1'b1; // RULE_02
            flush   = 1'b1;
            next_pc = {pc_high_latch[4:3], ir[10:0]}; // RULE_02
        end else if (ir[13:7] == 7'b0000011) begin
            result     = 8'h00; // RULE_03
            write_dest = 1'b1;
            next_zero  = 1'b1; // RULE_03
        end else if (ir[13:8] == 6'b001111) begin
            result = operand + 8'h01; // RULE_04
            if (result == 8'h00) begin
                flush = 1'b1; // RULE_04
            end
        end else if (ir[13:8] == 6'b000100) begin
            result    = accum | operand; // RULE_06
            next_zero = (result == 8'h00);
        end else if (ir[13:8] == 6'b111000) begin
            acc_load  = 1'b1;
            acc_value = accum | lit; // RULE_06
            next_zero = (acc_value == 8'h00);
        end else if (ir[13:10] == 4'b1100) begin
            acc_load  = 1'b1;
            acc_value = lit; // RULE_07
        end else if (ir[13:10] == 4'b1101) begin
            acc_load  = 1'b1;
            acc_value = lit; // RULE_10
            do_pop    = 1'b1;
            flush     = 1'b1;
            next_pc   = stack[sp - 3'd1]; // RULE_10
        end else if (ir[13:7] == 7'b0000001) begin
            result     = accum; // RULE_08
            write_dest = 1'b1;
        end else if (ir == `OP_OPTION) begin
            opt_load = 1'b1; // RULE_09
        end else if (ir == `OP_SLEEP) begin
            go_sleep = 1'b1; // RULE_13
        end else if ((ir == `OP_INTERRUPT_RETURN_OP) || (ir == `OP_RETURN)) begin
            do_pop  = 1'b1;
            flush   = 1'b1;
            next_pc = stack[sp - 3'd1]; // RULE_14
            set_gie = ir[0]; // RULE_14
        end else if (ir[13:8] == 6'b001101) begin
            result     = {operand[6:0], carry_flag}; // RULE_11
            next_carry = operand[7];
        end else if (ir[13:8] == 6'b001100) begin
            result     = {carry_flag, operand[7:1]}; // RULE_12
            next_carry = operand[0];
        end else if (ir[13:9] == 5'b11110) begin
            acc_load    = 1'b1;
            acc_value   = diff[7:0]; // RULE_15
            next_carry  = diff[8];
            next_dcarry = diff_lo[4];
            next_zero   = (diff[7:0] == 8'h00);
        end
        // Destination select for d-carrying register forms
        if (d_form) begin
            if (dest) begin
                write_dest = 1'b1; // RULE_05
            end else if (ir[11:8] != 4'b0000) begin
                acc_load  = 1'b1; // RULE_05
                acc_value = result;
            end
        end
    end

    // Instruction cycle enable divider
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_count <= {`CYC_CNT_W{1'b0}};
            cyc_en    <= 1'b0;
        end else begin
            div_count <= div_count + 1'b1;
            cyc_en    <= (div_count == `CYC_DIV - 1);
        end
    end

    wire bus_hit = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire bus_wr  = bus_hit & wb_we_i & wb_sel_i[0];

    // Fetch, program counter and stack
    always @(posedge clk_i) begin
        if (rst_i) begin
            prog_addr_o <= `RST_PC;
            ir          <= `NOP_WORD;
            sp          <= 3'd0;
        end else if (step) begin
            prog_addr_o <= next_pc;
            ir          <= flush ? `NOP_WORD : prog_data_i; // RULE_01 RULE_04
            if (do_push) begin
                stack[sp] <= prog_addr_o; // RULE_02
                sp        <= sp + 3'd1;
            end else if (do_pop) begin
                sp <= sp - 3'd1; // RULE_10 RULE_14
            end
        end
    end

    // Accumulator, flags and special registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            accum                 <= 8'h00;
            carry_flag            <= 1'b0;
            digit_carry_flag      <= 1'b0;
            zero_flag             <= 1'b0;
            option_reg            <= `RST_OPTION;
            interrupt_control_reg <= `RST_INTCTL;
            pc_high_latch         <= 8'h00;
        end else if (step) begin
            if (acc_load) begin
                accum <= acc_value;
            end
            if (opt_load) begin
                option_reg <= accum; // RULE_09
            end
            if (write_dest && (faddr == `FA_OPTION)) begin
                option_reg <= result;
            end
            if (write_dest && (faddr == `FA_PCLATCH)) begin
                pc_high_latch <= result;
            end
            if (write_dest && (faddr == `FA_INTCTL)) begin
                interrupt_control_reg <= result;
            end
            if (set_gie) begin
                interrupt_control_reg[`IC_GIE] <= 1'b1; // RULE_14
            end
            if (write_dest && (faddr == `FA_STATUS)) begin
                carry_flag       <= result[`ST_CARRY];
                digit_carry_flag <= result[`ST_DCARRY];
                zero_flag        <= result[`ST_ZERO];
            end
            if (next_carry != carry_flag) begin
                carry_flag <= next_carry;
            end
            if (next_dcarry != digit_carry_flag) begin
                digit_carry_flag <= next_dcarry;
            end
            if (next_zero != zero_flag) begin
                zero_flag <= next_zero;
            end
        end else if (bus_wr) begin
            case (wb_adr_i)
                `OFS_ACCUM:   accum <= wb_dat_i[7:0];
                `OFS_OPTION:  option_reg <= wb_dat_i[7:0]; // RULE_09
                `OFS_INTCTL:  interrupt_control_reg <= wb_dat_i[7:0];
                `OFS_PCLATCH: pc_high_latch <= wb_dat_i[7:0];
                `OFS_STATUS: begin
                    carry_flag       <= wb_dat_i[`ST_CARRY];
                    digit_carry_flag <= wb_dat_i[`ST_DCARRY];
                    zero_flag        <= wb_dat_i[`ST_ZERO];
                end
                default: ;
            endcase
        end
    end

    // Power-down, watchdog and run control
    always @(posedge clk_i) begin
        if (rst_i) begin
            sleep_o              <= 1'b0;
            watchdog_expiry_flag <= 1'b1;
            power_down_flag      <= 1'b1;
            wdog_count           <= 8'h00;
            wdog_presc           <= 8'h00;
            run                  <= 1'b0;
        end else begin
            if (step && go_sleep) begin
                wdog_count           <= 8'h00; // RULE_13
                wdog_presc           <= 8'h00;
                watchdog_expiry_flag <= 1'b1;
                power_down_flag      <= 1'b0;
                sleep_o              <= 1'b1; // RULE_13
            end else begin
                if (cyc_en && run && !sleep_o) begin
                    wdog_presc <= wdog_presc + 8'h01;
                    if (wdog_presc == 8'hFF) begin
                        wdog_count <= wdog_count + 8'h01;
                    end
                end
                if (bus_wr && (wb_adr_i == `OFS_CTRL) && wb_dat_i[`CTRL_WAKE]) begin
                    sleep_o <= 1'b0;
                end
            end
            if (bus_wr && (wb_adr_i == `OFS_CTRL)) begin
                run <= wb_dat_i[`CTRL_RUN];
            end
        end
    end

    // Wishbone classic slave, ack one cycle after request
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                case (wb_adr_i)
                    `OFS_CTRL:    wb_dat_o <= {31'h00000000, run};
                    `OFS_STATUS:  wb_dat_o <= {24'h000000, status_byte};
                    `OFS_ACCUM:   wb_dat_o <= {24'h000000, accum};
                    `OFS_PC:      wb_dat_o <= {19'h00000, prog_addr_o};
                    `OFS_OPTION:  wb_dat_o <= {24'h000000, option_reg};
                    `OFS_INTCTL:  wb_dat_o <= {24'h000000, interrupt_control_reg};
                    `OFS_PCLATCH: wb_dat_o <= {24'h000000, pc_high_latch};
                    `OFS_WDOG:    wb_dat_o <= {16'h0000, wdog_count, wdog_presc};
                    default:      wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // mcu_exec_core

//--- tb/mcu_exec_props.sv
// Checker for the execution core bus and fetch ports
`timescale 1ns/1ns
module mcu_exec_props (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire [13:0] prog_data_i,
    input wire [12:0] prog_addr_o,
    input wire        sleep_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_answer: assert property (s_req |=> s_ack_pulse)
        else $error("ack not a single pulse after request");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_dat_stands: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
    a_unmapped_zero: assert property (s_req ##0 (!wb_we_i && wb_adr_i == 8'h40)
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_fetch_spacing: assert property ($changed(prog_addr_o) |=> $stable(prog_addr_o) [*3])
        else $error("fetch address moved inside a cycle");
    a_halt_frozen: assert property (sleep_o |=> $stable(prog_addr_o))
        else $error("fetch while halted");
    a_halt_holds: assert property (sleep_o && !(wb_cyc_i && wb_stb_i) |=> sleep_o)
        else $error("halt left without wake");
    a_reset_state: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !sleep_o
        && prog_addr_o == 13'h0000 && wb_dat_o == 32'h0) else $error("bad reset state");
endmodule // mcu_exec_props

bind mcu_exec_core mcu_exec_props mcu_exec_props_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .prog_data_i(prog_data_i), .prog_addr_o(prog_addr_o), .sleep_o(sleep_o));

//--- tb/prog_rom.sv
// Program memory model with same-cycle read
`timescale 1ns/1ns
module prog_rom (
    input  wire [12:0] adr_i,
    output wire [13:0] dat_o
);
    logic [13:0] mem [0:63];

    assign dat_o = (adr_i < 13'h0040) ? mem[adr_i[5:0]] : 14'h0000;
endmodule // prog_rom

//--- tb/tb_top.sv
// Testbench for the execution core
`timescale 1ns/1ns
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    wire  [31:0] dat_o;
    wire         ack;
    wire         sleep;
    wire  [12:0] pa;
    wire  [13:0] pd;
    logic [13:0] prog [0:63];
    logic [7:0]  r, k, w, res;
    logic [31:0] exp_q [$];
    int          n_errors = 0;
    int          n_compared = 0;
    int          i;
    always #50 clk_i = ~clk_i;
    mcu_exec_core mcu_exec_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .prog_data_i(pd), .prog_addr_o(pa),
        .sleep_o(sleep));
    prog_rom prog_rom_inst (.adr_i(pa), .dat_o(pd));
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic bus(input logic w_i, input logic [7:0] a_i, input logic [3:0] s_i,
                       input logic [31:0] d_i, input logic [31:0] e_i);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_i;
        adr <= a_i;
        sel <= s_i;
        dat <= d_i;
        if (!w_i) exp_q.push_back(e_i);
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20) begin
            n_errors++;
            tally_and_finish();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) check(dat_o, exp_q.pop_front());
    end
    initial begin
        #2000000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(81));
        r = $urandom;
        k = $urandom;
        w = r | 8'h0F;
        res = k - w;
        prog = '{0: 14'h3081, 1: 14'h00A0, 2: 14'h01A1, 3: 14'h0DA0, 4: 14'h0CA1, 5: 14'h0421,
            6: 14'h008A, 7: 14'h30FF, 8: 14'h00A2, 9: 14'h0FA2, 10: 14'h008A, 11: 14'h1FA1,
            12: 14'h008A, 13: 14'h2020, 14: {6'h38, r}, 15: {6'h3C, k}, 16: 14'h0062,
            17: 14'h0063, 18: 14'h0420, 19: 14'h0063, 32: 14'h2028, 33: 14'h2030,
            34: 14'h340F, 40: 14'h0009, 48: 14'h0008, default: 14'h0000};
        prog_rom_inst.mem = prog;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h04, 4'hF, 32'h0, 32'h18);
        bus(1'b0, 8'h10, 4'hF, 32'h0, 32'hFF);
        bus(1'b0, 8'h14, 4'hF, 32'h0, 32'h0);
        bus(1'b0, 8'h18, 4'hF, 32'h0, 32'h0);
        bus(1'b0, 8'h40, 4'hF, 32'h0, 32'h0);
        bus(1'b1, 8'h08, 4'hE, {24'h0, ~r}, 32'h0);
        bus(1'b0, 8'h08, 4'hF, 32'h0, 32'h0);
        bus(1'b1, 8'h08, {3'($urandom), 1'b1}, {24'h0, r}, 32'h0);
        bus(1'b0, 8'h08, 4'hF, 32'h0, {24'h0, r});
        bus(1'b1, 8'h00, 4'hF, 32'h1, 32'h0);
        i = 0;
        while (sleep !== 1'b1 && i < 1000) begin
            @(posedge clk_i);
            i++;
        end
        check({31'h0, sleep}, 32'h1);
        bus(1'b0, 8'h08, 4'hF, 32'h0, {24'h0, res});
        bus(1'b0, 8'h04, 4'hF, 32'h0, {26'h0, 3'b110, res == 8'h00, k[3:0] >= w[3:0],
            k >= w});
        bus(1'b0, 8'h10, 4'hF, 32'h0, {24'h0, res});
        bus(1'b0, 8'h14, 4'hF, 32'h0, 32'h80);
        bus(1'b0, 8'h18, 4'hF, 32'h0, 32'h81);
        bus(1'b0, 8'h1C, 4'hF, 32'h0, 32'h0);
        bus(1'b0, 8'h0C, 4'hF, 32'h0, 32'h13);
        bus(1'b1, 8'h00, 4'hF, 32'h3, 32'h0);
        check({31'h0, sleep}, 32'h0);
        i = 0;
        while (sleep !== 1'b1 && i < 1000) begin
            @(posedge clk_i);
            i++;
        end
        check({31'h0, sleep}, 32'h1);
        bus(1'b0, 8'h08, 4'hF, 32'h0, {24'h0, res | 8'h02});
        tally_and_finish();
    end
endmodule // tb_top
